// File: adi_detect.sv
// Purpose: periodic accessory impedance detection with bias control
// Assumes: analogue front end measures on request and returns a band
// Notes: registers on classic Wishbone, one aligned word per register

`timescale 1ns/1ps

module adi_detect import adi_pkg::*; #(
  parameter int TICK_CYCLES = ADI_TICK_CYCLES,
  parameter int MEAS_TIMEOUT = ADI_MEAS_TIMEOUT_CYCLES
) (
  input wire logic clk_i,                  // system clock
  input wire logic rst_i,                  // synchronous reset
  input wire logic wb_cyc_i,               // bus cycle
  input wire logic wb_stb_i,               // strobe
  input wire logic wb_we_i,                // write enable
  input wire logic [ADI_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i,         // byte lanes
  input wire logic [31:0] wb_dat_i,        // write data
  output logic [31:0] wb_dat_o,            // read data
  output logic wb_ack_o,                   // acknowledge
  output logic bias_enable_o,              // bias reference two power
  output logic bias_ramp_slow_o,           // pop-free ramp select
  output logic bias_discharge_o,           // bias discharge control
  output logic measure_active_o,           // measurement request level
  input wire logic meas_done_i,            // measurement finished pulse
  input wire logic [7:0] meas_band_i,      // raw one-hot band, bit0 <3 ohm
  input wire logic meas_open_i,            // load above 30k ohm
  output logic detect_event_o              // change event pulse
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [15:0] control_ff;
  logic [7:0] band_enable_mask_ff;
  logic [2:0] bias_ctrl_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  adi_result_type result_ff;

  wire logic [3:0] bias_settle_delay = control_ff[ADI_SETTLE_LSB +: 4];
  wire logic [3:0] measure_interval = control_ff[ADI_INTERVAL_LSB +: 4];
  wire logic debounce_long = control_ff[ADI_DEBOUNCE_BIT];
  wire logic detect_on = control_ff[ADI_DETECT_ON_BIT];
  wire logic bias_ref_on = bias_ctrl_ff[ADI_BIAS_ON_BIT];

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire logic [7:0] bus_idx = wb_adr_i[ADI_ADR_W-1:2];
  wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire logic bus_wr = bus_req && wb_we_i;
  wire logic hit_control = (bus_idx == ADI_IDX_CONTROL);
  wire logic hit_band_en = (bus_idx == ADI_IDX_BAND_EN);
  wire logic hit_result = (bus_idx == ADI_IDX_RESULT);
  wire logic hit_bias = (bus_idx == ADI_IDX_BIAS);
  wire logic wr_control = bus_wr && hit_control;
  wire logic wr_band_en = bus_wr && hit_band_en && wb_sel_i[0];
  wire logic wr_bias = bus_wr && hit_bias && wb_sel_i[0];

  wire logic [15:0] result_word = {5'h00, result_ff.band,
    result_ff.valid, result_ff.present};

  wire logic [31:0] read_mux =
    hit_control ? {16'h0000, control_ff} :
    hit_band_en ? {24'h000000, band_enable_mask_ff} :
    hit_result ? {16'h0000, result_word} :
    hit_bias ? {29'h00000000, bias_ctrl_ff} :
    32'h00000000;

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req) begin
        rdata_ff <= read_mux;
      end
    end
  end

  // settle delay and interval fields, detection enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_ff <= ADI_CONTROL_RST;
    end else if (wr_control) begin
      if (wb_sel_i[1]) begin
        control_ff[15:8] <= wb_dat_i[15:8];
      end
      if (wb_sel_i[0]) begin
        control_ff[7:0] <= {6'h00, wb_dat_i[1:0]};
      end
    end
  end

  // bit seven is stored as written and ignored by the band logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      band_enable_mask_ff <= ADI_BAND_EN_RST;
    end else if (wr_band_en) begin
      band_enable_mask_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_ctrl_ff <= ADI_BIAS_RST;
    end else if (wr_bias) begin
      bias_ctrl_ff <= wb_dat_i[2:0];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ----------------------------------------------------------------------
  // band folding
  // ----------------------------------------------------------------------
  // enable bit k gates reported band k+1; band zero is always on
  logic [8:0] fold_pass;
  logic [7:0] folded_band;
  assign fold_pass[8] = 1'b0;

  genvar gi;
  generate
    for (gi = 7; gi >= 1; gi--) begin : g_fold
      wire logic hit = meas_band_i[gi] || fold_pass[gi+1];
      wire logic en = band_enable_mask_ff[gi-1];
      assign folded_band[gi] = hit && en;
      assign fold_pass[gi] = hit && !en;
    end
  endgenerate

  assign fold_pass[0] = 1'b0;
  assign folded_band[0] = meas_band_i[0] || fold_pass[1];

  wire logic [8:0] sample_band = meas_open_i ? 9'h000 :
    {1'b0, folded_band};
  wire logic sample_present = !meas_open_i;

  // ----------------------------------------------------------------------
  // measurement sequencer
  // ----------------------------------------------------------------------
  adi_state_type state_ff;
  adi_state_type nxt_state;
  logic timer_start;
  logic timer_done;
  logic [15:0] meas_cnt_ff;

  wire logic meas_timeout = (meas_cnt_ff == 16'(MEAS_TIMEOUT - 1));
  wire logic meas_end = (state_ff == ADI_MEASURE) &&
    (meas_done_i || meas_timeout);
  wire logic meas_good = (state_ff == ADI_MEASURE) && meas_done_i;
  wire logic [3:0] timer_code = (nxt_state == ADI_SETTLE) ?
    bias_settle_delay : measure_interval;

  always_comb begin
    nxt_state = state_ff;
    timer_start = 1'b0;
    case (state_ff)
      ADI_IDLE: begin
        if (detect_on) begin
          if (bias_ref_on) begin
            nxt_state = ADI_MEASURE;
          end else begin
            nxt_state = ADI_SETTLE;
            timer_start = 1'b1;
          end
        end
      end
      ADI_SETTLE: begin
        if (timer_done) begin
          nxt_state = ADI_MEASURE;
        end
      end
      ADI_MEASURE: begin
        if (meas_end) begin
          nxt_state = ADI_INTERVAL;
          timer_start = 1'b1;
        end
      end
      ADI_INTERVAL: begin
        if (timer_done) begin
          if (bias_ref_on) begin
            nxt_state = ADI_MEASURE;
          end else begin
            nxt_state = ADI_SETTLE;
            timer_start = 1'b1;
          end
        end
      end
      default: begin
        nxt_state = ADI_IDLE;
      end
    endcase
    if (!detect_on) begin
      nxt_state = ADI_IDLE;
      timer_start = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ADI_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff != ADI_MEASURE) begin
      meas_cnt_ff <= 16'h0000;
    end else if (!meas_timeout) begin
      meas_cnt_ff <= meas_cnt_ff + 16'h0001;
    end
  end

  adi_delay_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .abort_i(!detect_on),
    .start_i(timer_start),
    .code_i(timer_code),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------------
  // bias and front-end control
  // ----------------------------------------------------------------------
  wire logic seq_needs_bias = detect_on && (nxt_state == ADI_SETTLE ||
    nxt_state == ADI_MEASURE);
  logic bias_enable_ff;
  logic measure_active_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_enable_ff <= 1'b0;
      measure_active_ff <= 1'b0;
    end else begin
      bias_enable_ff <= bias_ref_on || seq_needs_bias;
      measure_active_ff <= (nxt_state == ADI_MEASURE);
    end
  end

  assign bias_enable_o = bias_enable_ff;
  assign measure_active_o = measure_active_ff;
  assign bias_ramp_slow_o = bias_ctrl_ff[ADI_RAMP_SLOW_BIT];
  assign bias_discharge_o = bias_ctrl_ff[ADI_DISCHARGE_BIT];

  // ----------------------------------------------------------------------
  // debounce and reporting
  // ----------------------------------------------------------------------
  logic [8:0] cand_band_ff;
  logic cand_present_ff;
  logic [2:0] cand_cnt_ff;
  logic event_ff;

  wire logic [2:0] db_need = debounce_long ? ADI_DB_LONG : ADI_DB_SHORT;
  wire logic same_cand = (sample_band == cand_band_ff) &&
    (sample_present == cand_present_ff) && (cand_cnt_ff != 3'h0);
  wire logic [2:0] nxt_cand_cnt = !same_cand ? 3'h1 :
    (cand_cnt_ff == db_need) ? cand_cnt_ff : cand_cnt_ff + 3'h1;
  wire logic commit = meas_good && (nxt_cand_cnt == db_need);
  wire logic changed = !result_ff.valid ||
    (result_ff.band != sample_band) ||
    (result_ff.present != sample_present);

  always_ff @(posedge clk_i) begin
    if (rst_i || !detect_on) begin
      cand_band_ff <= 9'h000;
      cand_present_ff <= 1'b0;
      cand_cnt_ff <= 3'h0;
    end else if (meas_good) begin
      cand_band_ff <= sample_band;
      cand_present_ff <= sample_present;
      cand_cnt_ff <= nxt_cand_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !detect_on) begin
      result_ff <= '0;
    end else if (commit) begin
      result_ff.band <= sample_band;
      result_ff.present <= sample_present;
      result_ff.valid <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_ff <= 1'b0;
    end else begin
      event_ff <= detect_on && commit && changed;
    end
  end

  assign detect_event_o = event_ff;

endmodule : adi_detect

// File: adi_pkg.sv
// Purpose: constants, types and helpers of the accessory impedance detect
// Assumes: 50 MHz system clock, registers on classic Wishbone, 32-bit data
// Notes: register indices are word indices; byte address is four times
//
// Notes on behaviour
// - Band-enable bits six to zero enable bands above 475 down to 14 ohm.
// - Measured band is a nine-bit one-hot field at result bits 10:2.
// - Result bit one is set only while the reported band is valid.
// - Result bit zero shows an accessory below 30k ohm is present.
// - Detection powers the second bias reference itself when measuring.
// - Without forced bias, power it only around each measurement.
// - Wait the programmed bias settle delay before measuring from cold.
// - A band in a disabled range reports as the next lower enabled band.
// - A measurement takes 100 to 500 us; high impedance finishes sooner.
// - All detection timing runs from the system clock.
// - With all bands on, tell a microphone from seven button loads.
// - Settle delay field 15:12, reset 0111, 0 to 512ms doubling steps.
// - Interval field 11:8, reset 0110, same coding as settle delay.
// - Raise an event on insertion, removal or impedance change.

package adi_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int ADI_CLK_MHZ = 50;
  localparam int ADI_TICK_US = 250;
  localparam int ADI_TICK_CYCLES = ADI_TICK_US * ADI_CLK_MHZ;
  localparam int ADI_MEAS_MAX_US = 500;
  localparam int ADI_MEAS_TIMEOUT_CYCLES = ADI_MEAS_MAX_US * ADI_CLK_MHZ;
  localparam int ADI_TICKS_W = 12;
  localparam logic [3:0] ADI_CODE_MAX = 4'hC;
  localparam logic [ADI_TICKS_W-1:0] ADI_TICKS_MAX = 12'h800;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int ADI_ADR_W = 10;
  localparam logic [7:0] ADI_IDX_CONTROL = 8'hD0;
  localparam logic [7:0] ADI_IDX_BAND_EN = 8'hD1;
  localparam logic [7:0] ADI_IDX_RESULT = 8'hD2;
  localparam logic [7:0] ADI_IDX_BIAS = 8'hD3;

  localparam int ADI_SETTLE_LSB = 12;
  localparam int ADI_INTERVAL_LSB = 8;
  localparam int ADI_DEBOUNCE_BIT = 1;
  localparam int ADI_DETECT_ON_BIT = 0;
  localparam int ADI_BAND_LSB = 2;
  localparam int ADI_VALID_BIT = 1;
  localparam int ADI_PRESENT_BIT = 0;
  localparam int ADI_DISCHARGE_BIT = 2;
  localparam int ADI_RAMP_SLOW_BIT = 1;
  localparam int ADI_BIAS_ON_BIT = 0;

  localparam logic [15:0] ADI_CONTROL_RST = 16'h7600;
  localparam logic [7:0] ADI_BAND_EN_RST = 8'h7F;
  localparam logic [2:0] ADI_BIAS_RST = 3'h0;

  localparam logic [2:0] ADI_DB_SHORT = 3'h2;
  localparam logic [2:0] ADI_DB_LONG = 3'h4;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ADI_IDLE = 2'h0,
    ADI_SETTLE = 2'h1,
    ADI_MEASURE = 2'h3,
    ADI_INTERVAL = 2'h2
  } adi_state_type;

  typedef struct packed {
    logic [8:0] band;
    logic valid;
    logic present;
  } adi_result_type;

  // delay code to quarter-millisecond ticks: 0, then doubling, capped
  function automatic logic [ADI_TICKS_W-1:0] adi_code_ticks(
    input logic [3:0] code
  );
    logic [ADI_TICKS_W-1:0] t;
    t = '0;
    if (code >= ADI_CODE_MAX) begin
      t = ADI_TICKS_MAX;
    end else if (code != 4'h0) begin
      t = 12'h001 << (code - 4'h1);
    end
    return t;
  endfunction : adi_code_ticks

endpackage : adi_pkg

// File: adi_delay_timer.sv
// Purpose: delay of a coded number of quarter-millisecond ticks
// Assumes: start restarts the tick divider, so no partial first tick
// Notes: code zero gives done one cycle after start

`timescale 1ns/1ps

module adi_delay_timer import adi_pkg::*; #(
  parameter int TICK_CYCLES = ADI_TICK_CYCLES
) (
  input wire logic clk_i,        // system clock
  input wire logic rst_i,        // synchronous reset
  input wire logic abort_i,      // stop without done
  input wire logic start_i,      // load code and start
  input wire logic [3:0] code_i, // delay code
  output logic done_o            // one-cycle pulse at expiry
);

  logic [ADI_TICKS_W-1:0] ticks_ff;
  logic [15:0] cyc_ff;
  logic busy_ff;
  logic done_ff;
  wire logic [ADI_TICKS_W-1:0] load_ticks = adi_code_ticks(code_i);
  wire logic tick = (cyc_ff == 16'(TICK_CYCLES - 1));
  wire logic last = busy_ff && tick && (ticks_ff == 12'h001);

  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      ticks_ff <= '0;
      cyc_ff <= '0;
    end else if (start_i) begin
      ticks_ff <= load_ticks;
      cyc_ff <= '0;
      busy_ff <= (load_ticks != '0);
      done_ff <= (load_ticks == '0);
    end else begin
      done_ff <= last;
      if (busy_ff) begin
        cyc_ff <= tick ? 16'h0000 : cyc_ff + 16'h0001;
        if (tick) begin
          ticks_ff <= ticks_ff - 12'h001;
        end
        if (last) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end

  assign done_o = done_ff;

endmodule : adi_delay_timer

// File: adi_detect_chk.sv
// Purpose: port checks for the accessory impedance detect
// Assumes: master holds each request until it samples ack high
// Notes: bus writes are decoded here to follow detect and bias enables
`timescale 1ns/1ps
module adi_detect_chk import adi_pkg::*; #(
  parameter int TICK_CYCLES = ADI_TICK_CYCLES,
  parameter int MEAS_TIMEOUT = ADI_MEAS_TIMEOUT_CYCLES
) (
  input wire logic clk_i,                    // system clock
  input wire logic rst_i,                    // synchronous reset
  input wire logic wb_cyc_i,                 // bus cycle
  input wire logic wb_stb_i,                 // strobe
  input wire logic wb_we_i,                  // write enable
  input wire logic [ADI_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i,           // byte lanes
  input wire logic [31:0] wb_dat_i,          // write data
  input wire logic [31:0] wb_dat_o,          // read data
  input wire logic wb_ack_o,                 // acknowledge
  input wire logic bias_enable_o,            // bias power
  input wire logic bias_ramp_slow_o,         // ramp select
  input wire logic bias_discharge_o,         // discharge
  input wire logic measure_active_o,         // measurement request
  input wire logic meas_done_i,              // measurement done
  input wire logic [7:0] meas_band_i,        // raw band
  input wire logic meas_open_i,              // open load
  input wire logic detect_event_o            // change event
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic det_ff;
  logic forced_ff;
  logic [15:0] meas_cnt_ff;
  logic wr_hit;
  logic rd_res;
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign rd_res = wb_ack_o && wb_cyc_i && !wb_we_i
    && wb_adr_i[9:2] == ADI_IDX_RESULT;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_ff <= 1'b0;
      forced_ff <= 1'b0;
    end else if (wr_hit && wb_adr_i[9:2] == ADI_IDX_CONTROL) begin
      det_ff <= wb_dat_i[0];
    end else if (wr_hit && wb_adr_i[9:2] == ADI_IDX_BIAS) begin
      forced_ff <= wb_dat_i[0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !measure_active_o) begin
      meas_cnt_ff <= 16'h0000;
    end else begin
      meas_cnt_ff <= meas_cnt_ff + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered next cycle");
  property p_res_upper; rd_res |-> wb_dat_o[31:10] == '0; endproperty
  a_res_upper: assert property (p_res_upper)
    else $error("result upper bits not zero");
  property p_res_invalid; rd_res && !wb_dat_o[1] |-> wb_dat_o[10:0] == '0;
  endproperty
  a_res_invalid: assert property (p_res_invalid)
    else $error("invalid result carries data");
  property p_res_present; rd_res && wb_dat_o[1] |-> (wb_dat_o[0] ?
    $onehot(wb_dat_o[10:2]) : wb_dat_o[10:2] == '0); endproperty
  a_res_present: assert property (p_res_present)
    else $error("band and presence disagree");
  property p_bias_meas; measure_active_o |-> bias_enable_o; endproperty
  a_bias_meas: assert property (p_bias_meas)
    else $error("measuring without bias");
  property p_bias_drop; $fell(measure_active_o) && !forced_ff
    |-> !bias_enable_o; endproperty
  a_bias_drop: assert property (p_bias_drop)
    else $error("bias kept on between measurements");
  property p_done_ends; measure_active_o && meas_done_i
    |=> !measure_active_o; endproperty
  a_done_ends: assert property (p_done_ends)
    else $error("measurement not ended by done");
  property p_meas_bound; meas_cnt_ff <= MEAS_TIMEOUT + 1; endproperty
  a_meas_bound: assert property (p_meas_bound)
    else $error("measurement exceeds timeout");
  property p_off_idle; !det_ff |-> !measure_active_o
    && bias_enable_o == forced_ff; endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("activity while detection off");
  property p_evt_pulse; detect_event_o |=> !detect_event_o; endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("event longer than one cycle");
  c_event: cover property (detect_event_o);
  c_done: cover property (measure_active_o && meas_done_i);
  c_forced: cover property (forced_ff && $fell(measure_active_o));
  c_timeout: cover property (meas_cnt_ff == MEAS_TIMEOUT);
endmodule : adi_detect_chk

bind adi_detect adi_detect_chk #(.TICK_CYCLES(TICK_CYCLES),
  .MEAS_TIMEOUT(MEAS_TIMEOUT)) u_adi_detect_chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .bias_enable_o, .bias_ramp_slow_o,
  .bias_discharge_o, .measure_active_o, .meas_done_i, .meas_band_i,
  .meas_open_i, .detect_event_o);

// File: adi_front_end_model.sv
// Purpose: analogue front end answering measurement requests
// Assumes: one answer per request level
// Notes: lines show inverted data outside the done pulse
`timescale 1ns/1ps
module adi_front_end_model (
  input wire logic clk_i,            // system clock
  input wire logic rst_i,            // synchronous reset
  input wire logic measure_active_i, // request level
  input wire logic [2:0] band_idx_i, // band to report
  input wire logic open_i,           // no accessory fitted
  input wire logic mute_i,           // never answer
  output logic meas_done_o,          // finished pulse
  output logic [7:0] meas_band_o,    // one-hot band
  output logic meas_open_o           // load above 30k ohm
);
  logic [3:0] cnt_ff;
  logic fired_ff;
  logic [3:0] lat;
  logic [7:0] hot;
  // high impedance answers sooner
  assign lat = open_i ? 4'h3 : 4'hC - {1'b0, band_idx_i};
  assign hot = 8'h01 << band_idx_i;
  assign meas_band_o = meas_done_o ? hot : ~hot;
  assign meas_open_o = meas_done_o ? open_i : !open_i;
  always_ff @(posedge clk_i) begin
    if (rst_i || !measure_active_i) begin
      cnt_ff <= 4'h0;
      fired_ff <= 1'b0;
      meas_done_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      meas_done_o <= cnt_ff == lat && !fired_ff && !mute_i;
      fired_ff <= fired_ff || cnt_ff == lat;
    end
  end
endmodule : adi_front_end_model

// File: accessory_impedance_detect_bench.sv
// Purpose: directed bench for the accessory impedance detect
// Assumes: shortened tick and measurement timeout
// Notes: front end model answers every measurement request except while mute is set
`timescale 1ns/1ps
module accessory_impedance_detect_bench import adi_pkg::*;;
  localparam int TICK = 4;
  localparam int MEAS_TO = 50;
  localparam logic [7:0] RIDX [5] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'h10};
  localparam logic [31:0] RVAL [5] = '{32'h7600, 32'h7F, 0, 0, 0};
  localparam logic [31:0] FEN [2] = '{32'h77, 32'h3F};
  localparam logic [2:0] FRAW [2] = '{3'h4, 3'h7};
  localparam int FEXP [2] = '{3, 6};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADI_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic bias_enable_o;
  logic bias_ramp_slow_o;
  logic bias_discharge_o;
  logic measure_active_o;
  logic meas_done_i;
  logic [7:0] meas_band_i;
  logic meas_open_i;
  logic detect_event_o;
  logic [2:0] band_idx = 3'h0;
  logic open_load = 1'b0;
  logic mute = 1'b0;
  int dn;
  logic [31:0] rd;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  always #10 clk_i = ~clk_i;
  adi_detect #(.TICK_CYCLES(TICK), .MEAS_TIMEOUT(MEAS_TO)) u_adi_detect (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .bias_enable_o, .bias_ramp_slow_o,
    .bias_discharge_o, .measure_active_o, .meas_done_i, .meas_band_i,
    .meas_open_i, .detect_event_o);
  adi_front_end_model u_adi_front_end_model (.clk_i, .rst_i,
    .measure_active_i(measure_active_o), .band_idx_i(band_idx),
    .open_i(open_load), .mute_i(mute), .meas_done_o(meas_done_i),
    .meas_band_o(meas_band_i), .meas_open_o(meas_open_i));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic bus(input logic we, input logic [7:0] idx,
    input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 20) begin
      k++;
      @(posedge clk_i);
    end
    check("ack", 32'(wb_ack_o), 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus
  task automatic rd_chk(input string name, input logic [7:0] idx,
    input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask : rd_chk
  task automatic wait_evt();
    int k;
    k = 0;
    dn = 0;
    while (detect_event_o !== 1'b1 && k < 3000) begin
      k++;
      @(posedge clk_i);
      if (meas_done_i === 1'b1 && measure_active_o === 1'b1) dn++;
    end
    check("event", 32'(detect_event_o), 32'h1);
  endtask : wait_evt
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd_chk("reset", RIDX[i], RVAL[i]);
    end
    bus(1'b1, ADI_IDX_RESULT, 32'hFFFF);
    rd_chk("result ro", ADI_IDX_RESULT, 32'h0);
    bus(1'b1, 8'h10, 32'hFFFF);
    rd_chk("unmapped", 8'h10, 32'h0);
    // settle code 3, interval 0, detection on
    bus(1'b1, ADI_IDX_CONTROL, 32'h30FD);
    n = 0;
    while (measure_active_o !== 1'b1 && n < 200) begin
      if (bias_enable_o === 1'b1) n++;
      @(posedge clk_i);
    end
    check("settle", 32'(n >= 4 * TICK && n <= 4 * TICK + 3), 1);
    rd_chk("control", ADI_IDX_CONTROL, 32'h3001);
    for (int k = 0; k < 8; k++) begin
      band_idx <= 3'(k);
      wait_evt();
      rd_chk("band", ADI_IDX_RESULT, 32'h3 | (32'h4 << k));
    end
    open_load <= 1'b1;
    wait_evt();
    rd_chk("open", ADI_IDX_RESULT, 32'h2);
    open_load <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADI_IDX_BAND_EN, FEN[k]);
      band_idx <= FRAW[k];
      wait_evt();
      rd_chk("fold", ADI_IDX_RESULT, 32'h3 | (32'h4 << FEXP[k]));
    end
    // long debounce: four equal results before a commit
    bus(1'b1, ADI_IDX_CONTROL, 32'h30FF);
    band_idx <= 3'h2;
    wait_evt();
    check("debounce", dn, 4);
    rd_chk("long", ADI_IDX_RESULT, 32'h13);
    bus(1'b1, ADI_IDX_BIAS, 32'h7);
    @(posedge clk_i);
    check("ramp", {bias_ramp_slow_o, bias_discharge_o}, 32'h3);
    band_idx <= 3'h1;
    wait_evt();
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (bias_enable_o !== 1'b1) n++;
    end
    check("forced bias", n, 0);
    // silent front end: measurement ends on the timeout
    mute <= 1'b1;
    n = 0;
    while (measure_active_o !== 1'b0 && n < 200) begin
      n++;
      @(posedge clk_i);
    end
    while (measure_active_o !== 1'b1 && n < 400) begin
      n++;
      @(posedge clk_i);
    end
    n = 0;
    while (measure_active_o === 1'b1 && n < 200) begin
      n++;
      @(posedge clk_i);
    end
    check("timeout", n, MEAS_TO);
    mute <= 1'b0;
    bus(1'b1, ADI_IDX_CONTROL, 32'h3000);
    repeat (2) @(posedge clk_i);
    check("idle", {measure_active_o, bias_enable_o}, 32'h1);
    rd_chk("cleared", ADI_IDX_RESULT, 32'h0);
    bus(1'b1, ADI_IDX_BIAS, 32'h0);
    repeat (2) @(posedge clk_i);
    check("bias off", {bias_enable_o, bias_discharge_o}, 32'h0);
    results();
  end
  initial begin
    #400000;
    num_errors++;
    results();
  end
endmodule : accessory_impedance_detect_bench
